//--- logic/seq_pkg.sv
// shared constants for the reader command sequencer
// assumes a single 25 MHz clock domain and byte-wide fifo ports
package seq_pkg;
   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [3:0] CMD_IDLE      = 4'h0;
   localparam logic [3:0] CMD_MEM       = 4'h1;
   localparam logic [3:0] CMD_RANDOM    = 4'h2;
   localparam logic [3:0] CMD_CHECKSUM  = 4'h3;
   localparam logic [3:0] CMD_TRANSMIT  = 4'h4;
   localparam logic [3:0] CMD_KEEP      = 4'h7;
   localparam logic [3:0] CMD_RECEIVE   = 4'h8;
   localparam logic [3:0] CMD_TRANSCV   = 4'hC;
   localparam logic [3:0] CMD_RESERVED  = 4'hD;
   localparam logic [3:0] CMD_AUTH      = 4'hE;
   localparam logic [3:0] CMD_SWRESET   = 4'hF;
   // ------------------------------------------------------------
   // counts and reset values
   // ------------------------------------------------------------
   localparam int         BUF_BYTES     = 25;
   localparam int         RAND_BYTES    = 10;
   localparam int         AUTH_ARGS     = 12;
   localparam int         SELFTEST_BYTES = 64;
   localparam logic [3:0] SELFTEST_ON   = 4'h9;
   localparam logic [7:0] LFSR_SEED     = 8'hA5;
   localparam logic [7:0] SELFTEST_SEED = 8'h3C;
   localparam logic [5:0] SWRESET_CYCLES = 6'h08;
endpackage

//--- logic/fifo_port_if.sv
// fifo side signals between the sequencer and its byte mover
// assumes the fifo itself lives outside the block
`timescale 1ns/1ps
interface fifo_port_if;
   logic       empty;
   logic       rd_en;
   logic [7:0] rd_data;
   logic       wr_en;
   logic [7:0] wr_data;
   modport mover (input empty, input rd_data, output rd_en, output wr_en, output wr_data);
   modport seq (output empty, output rd_data, input rd_en, input wr_en, input wr_data);
endinterface

//--- logic/retained_buffer.sv
// 25 byte retained buffer with byte read and write port
// assumes it sits on the always-on supply: no reset clears it
`timescale 1ns/1ps
module retained_buffer #(
   parameter int DEPTH = seq_pkg::BUF_BYTES
) (
   // clock
   input  wire logic       clk_i,
   // access port
   input  wire logic       we_i,
   input  wire logic [4:0] addr_i,
   input  wire logic [7:0] wdata_i,
   output      logic [7:0] rdata_o
);
   initial begin
      if (DEPTH < 1 || DEPTH > 32) $error("retained_buffer depth out of range");
   end
   logic [7:0] mem [DEPTH];
   // -----------------------------------------------------------
   // storage, deliberately free of any reset
   // -----------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
   end
endmodule

//--- logic/reader_command_sequencer.sv
// reader command sequencer: decodes the command field and runs commands
// assumes fifo, transmitter, receiver, crc and crypto units sit outside
// Notes on behaviour
// - a written command code selects which command the sequencer executes
// - all arguments and data move through the fifo only
// - stream commands consume fifo at once; send-then-listen waits start-send
// - fixed-argument commands wait until all argument bytes are taken
// - starting a command never flushes the fifo
// - a new code other than 0111 abandons the running command immediately
// - code 0000 is idle and cancels the running command
// - idle completes itself and stays idle until a new code
// - code 0001 copies 25 fifo bytes into the retained buffer
// - buffer command with empty fifo copies the 25 buffer bytes out
// - retained buffer survives hard power-down, lost only on supply loss
// - buffer command returns to idle when transfer ends
// - code 0010 writes 10 random bytes into the buffer then idles
// - code 0011 feeds fifo to crc, pauses when empty, never limited
// - crc preset loads at start; host must end the crc command
// - with self-test enabled the crc command writes self-test bytes
// - code 0100 transmits fifo and ends when fifo runs empty and tx_done_i is set
// - code 0111 keeps command, updates sleep and receiver-off bits
// - code 1000 switches the receiver on and waits for data
// - code 1100 transmits then switches receiver on automatically
// - code 1101 is reserved and selects nothing
// - code 1110 runs card authentication as reader
// - code 1111 resets registers, keeps buffer, then ends itself
// - receive ends when the receiver reports end of frame
`timescale 1ns/1ps
module reader_command_sequencer (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // command register write
   input  wire logic       cmd_wr_i,
   input  wire logic [3:0] cmd_code_i,
   input  wire logic       sleep_request_bit_i,
   input  wire logic       receiver_off_bit_i,
   input  wire logic       start_send_flag_i,
   input  wire logic [1:0] crc_preset_field_i,
   input  wire logic [3:0] self_test_field_i,
   // fifo
   input  wire logic       fifo_empty_i,
   input  wire logic [7:0] fifo_rd_data_i,
   output      logic       fifo_rd_o,
   output      logic       fifo_wr_o,
   output      logic [7:0] fifo_wr_data_o,
   // transmitter, receiver, crc, crypto
   output      logic       tx_byte_valid_o,
   output      logic [7:0] tx_byte_o,
   output      logic       tx_active_o,
   input  wire logic       tx_done_i,
   output      logic       rx_on_o,
   input  wire logic       rx_end_i,
   output      logic       crc_load_o,
   output      logic [1:0] crc_preset_o,
   output      logic       crc_byte_valid_o,
   output      logic [7:0] crc_byte_o,
   output      logic       auth_start_o,
   output      logic       auth_arg_valid_o,
   output      logic [7:0] auth_arg_o,
   input  wire logic       auth_done_i,
   // status
   output      logic [3:0] command_o,
   output      logic       sleep_request_bit_o,
   output      logic       receiver_off_bit_o,
   output      logic       soft_reset_o
);
   typedef enum logic [9:0] {
      ST_IDLE  = 10'b0000000001,
      ST_M_IN  = 10'b0000000010,
      ST_M_OUT = 10'b0000000100,
      ST_RAND  = 10'b0000001000,
      ST_CRC   = 10'b0000010000,
      ST_TEST  = 10'b0000100000,
      ST_TX    = 10'b0001000000,
      ST_RX    = 10'b0010000000,
      ST_AUTH  = 10'b0100000000,
      ST_RST   = 10'b1000000000
   } state_t;

   typedef struct packed {
      state_t     st;
      logic [3:0] cmd;
      logic       sleep;
      logic       rxoff;
      logic       tcv;       // running send-then-listen
      logic       tcv_arm;   // start-send seen for this round
      logic [5:0] cnt;
      logic [7:0] lfsr;
      logic       rd;
      logic       wr;
      logic [7:0] wdata;
      logic       txv;
      logic [7:0] txb;
      logic       txa;
      logic       rxon;
      logic       crcl;
      logic       crcv;
      logic [7:0] crcb;
      logic [1:0] crcp;      // preset held for the crc engine
      logic       auths;
      logic       authv;
      logic [7:0] autha;
      logic       srst;
      logic       pend;      // byte read last cycle, data valid now
      logic       mout;      // buffer read staged for fifo write
   } seq_t;

   seq_t s_r;
   seq_t s_nxt;

   fifo_port_if fp ();
   logic       buf_we;
   logic [4:0] buf_addr;
   logic [7:0] buf_rdata;
   logic [7:0] buf_wdata;

   // ------------------------------------------------------------
   // retained buffer; no reset port so power-down keeps it
   // ------------------------------------------------------------
   retained_buffer #(.DEPTH(seq_pkg::BUF_BYTES)) u_buf (
      .clk_i   (clk_i),
      .we_i    (buf_we),
      .addr_i  (buf_addr),
      .wdata_i (buf_wdata),
      .rdata_o (buf_rdata)
   );

   // fifo side bundle, carried through the interface
   assign fp.empty   = fifo_empty_i;
   assign fp.rd_data = fifo_rd_data_i;
   assign fp.rd_en   = s_r.rd;
   assign fp.wr_en   = s_r.wr;
   assign fp.wr_data = s_r.wdata;

   // buffer port: fifo bytes or random bytes land here
   always_comb begin
      buf_we    = 1'b0;
      buf_wdata = fp.rd_data;
      buf_addr  = s_r.cnt[4:0];
      if (s_r.st == ST_M_IN && s_r.pend) begin
         buf_we = 1'b1;
      end else if (s_r.st == ST_RAND) begin
         buf_we    = 1'b1;
         buf_wdata = s_r.lfsr;
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt       = s_r;
      s_nxt.rd    = 1'b0;
      s_nxt.wr    = 1'b0;
      s_nxt.txv   = 1'b0;
      s_nxt.crcl  = 1'b0;
      s_nxt.crcv  = 1'b0;
      s_nxt.auths = 1'b0;
      s_nxt.authv = 1'b0;
      s_nxt.srst  = 1'b0;
      s_nxt.pend  = s_r.rd;
      s_nxt.mout  = 1'b0;
      s_nxt.lfsr  = {s_r.lfsr[6:0], s_r.lfsr[7] ^ s_r.lfsr[5] ^ s_r.lfsr[4] ^ s_r.lfsr[3]};
      // per-command work; fifo is never cleared here
      case (s_r.st)
         ST_IDLE: begin
            s_nxt.txa  = 1'b0;
            s_nxt.rxon = 1'b0;
         end
         ST_M_IN: begin
            if (s_r.pend) begin
               s_nxt.cnt = s_r.cnt + 6'h01;
               if (s_r.cnt == 6'(seq_pkg::BUF_BYTES - 1)) begin
                  s_nxt.st  = ST_IDLE;
                  s_nxt.cmd = seq_pkg::CMD_IDLE;
               end
            end
            // one byte in flight at a time keeps the count exact
            if (!fp.empty && !s_r.rd && !s_r.pend
                && s_r.cnt < 6'(seq_pkg::BUF_BYTES)) begin
               s_nxt.rd = 1'b1;
            end
         end
         ST_M_OUT: begin
            if (s_r.mout) begin
               s_nxt.wr    = 1'b1;
               s_nxt.wdata = buf_rdata;
               s_nxt.cnt   = s_r.cnt + 6'h01;
               if (s_r.cnt == 6'(seq_pkg::BUF_BYTES - 1)) begin
                  s_nxt.st  = ST_IDLE;
                  s_nxt.cmd = seq_pkg::CMD_IDLE;
               end
            end else begin
               s_nxt.mout = 1'b1; // wait one cycle for buffer read
            end
         end
         ST_RAND: begin
            s_nxt.cnt = s_r.cnt + 6'h01;
            if (s_r.cnt == 6'(seq_pkg::RAND_BYTES - 1)) begin
               s_nxt.st  = ST_IDLE;
               s_nxt.cmd = seq_pkg::CMD_IDLE;
            end
         end
         ST_CRC: begin
            if (s_r.pend) begin
               s_nxt.crcv = 1'b1;
               s_nxt.crcb = fp.rd_data;
            end
            if (!fp.empty && !s_r.rd && !s_r.pend) begin
               s_nxt.rd = 1'b1;
            end
         end
         ST_TEST: begin
            if (s_r.cnt < 6'(seq_pkg::SELFTEST_BYTES - 1)) begin
               s_nxt.wr    = 1'b1;
               s_nxt.wdata = s_r.lfsr ^ seq_pkg::SELFTEST_SEED;
               s_nxt.cnt   = s_r.cnt + 6'h01;
            end
         end
         ST_TX: begin
            if (s_r.tcv && !s_r.tcv_arm) begin
               s_nxt.tcv_arm = start_send_flag_i;
            end else begin
               s_nxt.txa = 1'b1;
               if (s_r.pend) begin
                  s_nxt.txv = 1'b1;
                  s_nxt.txb = fp.rd_data;
               end
               if (!fp.empty && !s_r.rd && !s_r.pend) begin
                  s_nxt.rd = 1'b1;
               end else if (fp.empty && !s_r.rd && !s_r.pend && tx_done_i) begin
                  s_nxt.txa = 1'b0;
                  if (s_r.tcv) begin
                     s_nxt.st      = ST_RX;
                     s_nxt.rxon    = 1'b1;
                     s_nxt.tcv_arm = 1'b0;
                  end else begin
                     s_nxt.st  = ST_IDLE;
                     s_nxt.cmd = seq_pkg::CMD_IDLE;
                  end
               end
            end
         end
         ST_RX: begin
            s_nxt.rxon = 1'b1;
            if (rx_end_i) begin
               s_nxt.rxon = 1'b0;
               if (s_r.tcv) begin
                  s_nxt.st = ST_TX;
               end else begin
                  s_nxt.st  = ST_IDLE;
                  s_nxt.cmd = seq_pkg::CMD_IDLE;
               end
            end
         end
         ST_AUTH: begin
            if (s_r.pend) begin
               s_nxt.authv = 1'b1;
               s_nxt.autha = fp.rd_data;
               s_nxt.cnt   = s_r.cnt + 6'h01;
               if (s_r.cnt == 6'(seq_pkg::AUTH_ARGS - 1)) begin
                  s_nxt.auths = 1'b1;
               end
            end
            if (!fp.empty && !s_r.rd && !s_r.pend
                && s_r.cnt < 6'(seq_pkg::AUTH_ARGS)) begin
               s_nxt.rd = 1'b1;
            end
            if (auth_done_i && s_r.cnt == 6'(seq_pkg::AUTH_ARGS)) begin
               s_nxt.st  = ST_IDLE;
               s_nxt.cmd = seq_pkg::CMD_IDLE;
            end
         end
         ST_RST: begin
            s_nxt.srst = 1'b1;
            s_nxt.cnt  = s_r.cnt + 6'h01;
            if (s_r.cnt == seq_pkg::SWRESET_CYCLES) begin
               s_nxt       = '0;
               s_nxt.st    = ST_IDLE;
               s_nxt.lfsr  = s_r.lfsr;
               s_nxt.cmd   = seq_pkg::CMD_IDLE;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase

      // a command write other than 0111 overrides whatever ran above
      if (cmd_wr_i) begin
         s_nxt.sleep = sleep_request_bit_i;
         s_nxt.rxoff = receiver_off_bit_i;
         if (cmd_code_i != seq_pkg::CMD_KEEP) begin
            s_nxt.cmd     = cmd_code_i;
            s_nxt.cnt     = 6'h00;
            s_nxt.rd      = 1'b0;
            s_nxt.pend    = 1'b0;
            s_nxt.txa     = 1'b0;
            s_nxt.rxon    = 1'b0;
            s_nxt.tcv     = 1'b0;
            s_nxt.tcv_arm = 1'b0;
            case (cmd_code_i)
               seq_pkg::CMD_MEM:      s_nxt.st = fp.empty ? ST_M_OUT : ST_M_IN;
               seq_pkg::CMD_RANDOM:   s_nxt.st = ST_RAND;
               seq_pkg::CMD_CHECKSUM: begin
                  if (self_test_field_i == seq_pkg::SELFTEST_ON) begin
                     s_nxt.st   = ST_TEST;
                     s_nxt.lfsr = seq_pkg::LFSR_SEED;
                  end else begin
                     s_nxt.st   = ST_CRC;
                     s_nxt.crcl = 1'b1;
                     s_nxt.crcp = crc_preset_field_i;
                  end
               end
               seq_pkg::CMD_TRANSMIT: s_nxt.st = ST_TX;
               seq_pkg::CMD_RECEIVE:  s_nxt.st = ST_RX;
               seq_pkg::CMD_TRANSCV: begin
                  s_nxt.st  = ST_TX;
                  s_nxt.tcv = 1'b1;
               end
               seq_pkg::CMD_AUTH:     s_nxt.st = ST_AUTH;
               seq_pkg::CMD_SWRESET:  s_nxt.st = ST_RST;
               seq_pkg::CMD_IDLE:     s_nxt.st = ST_IDLE;
               default: begin
                  s_nxt.st  = ST_IDLE;
                  s_nxt.cmd = seq_pkg::CMD_IDLE;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r      <= '0;
         s_r.st   <= ST_IDLE;
         s_r.lfsr <= seq_pkg::LFSR_SEED;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state flops
   assign fifo_rd_o           = fp.rd_en;
   assign fifo_wr_o           = fp.wr_en;
   assign fifo_wr_data_o      = fp.wr_data;
   assign tx_byte_valid_o     = s_r.txv;
   assign tx_byte_o           = s_r.txb;
   assign tx_active_o         = s_r.txa;
   assign rx_on_o             = s_r.rxon;
   assign crc_load_o          = s_r.crcl;
   assign crc_preset_o        = s_r.crcp;
   assign crc_byte_valid_o    = s_r.crcv;
   assign crc_byte_o          = s_r.crcb;
   assign auth_start_o        = s_r.auths;
   assign auth_arg_valid_o    = s_r.authv;
   assign auth_arg_o          = s_r.autha;
   assign command_o           = s_r.cmd;
   assign sleep_request_bit_o = s_r.sleep;
   assign receiver_off_bit_o  = s_r.rxoff;
   assign soft_reset_o        = s_r.srst;
endmodule

//--- tb/fifo_model.sv
// byte fifo standing on the far side of the sequencer
// assumes reads pop one byte, valid the cycle after the read pulse
`timescale 1ns/1ps
module fifo_model (
   // clock
   input  wire logic       clk_i,
   // sequencer side
   input  wire logic       rd_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   output      logic       empty_o,
   output      logic [7:0] rdata_o
);
   logic [7:0] q[$];
   initial begin
      rdata_o = 8'h00;
      empty_o = 1'b1;
   end
   // stale read data is inverted so nothing reads it by luck; empty is
   // refreshed each edge since a queue change wakes no continuous assign
   always @(posedge clk_i) begin
      rdata_o <= ~rdata_o;
      if (rd_i && q.size() > 0) rdata_o <= q.pop_front();
      if (wr_i) q.push_back(wdata_i);
      empty_o <= (q.size() == 0);
   end
endmodule

//--- tb/reader_command_sequencer_asserts.sv
// port assertions for the reader command sequencer
// assumes one clock domain with the active-low asynchronous reset
`timescale 1ns/1ps
module seq_asserts (
   input wire logic       clk_i,
   input wire logic       rstn_i,
   input wire logic       cmd_wr_i,
   input wire logic [3:0] cmd_code_i,
   input wire logic       sleep_request_bit_i,
   input wire logic       start_send_flag_i,
   input wire logic [1:0] crc_preset_field_i,
   input wire logic [3:0] self_test_field_i,
   input wire logic       fifo_empty_i,
   input wire logic       rx_end_i,
   input wire logic       fifo_rd_o,
   input wire logic       tx_byte_valid_o,
   input wire logic       rx_on_o,
   input wire logic       crc_load_o,
   input wire logic [1:0] crc_preset_o,
   input wire logic [3:0] command_o,
   input wire logic       sleep_request_bit_o,
   input wire logic       soft_reset_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // defined codes other than 0111 show up as the running command
   a_code_selects: assert property (cmd_wr_i && cmd_code_i inside
      {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC, 4'hE, 4'hF}
      |=> command_o == $past(cmd_code_i)) else $error("code not taken");
   a_undef_idle: assert property (cmd_wr_i && cmd_code_i inside
      {4'h5, 4'h6, 4'h9, 4'hA, 4'hB, 4'hD} |=> command_o == 4'h0)
      else $error("undefined code not idle");
   a_keep_code: assert property (cmd_wr_i && cmd_code_i == 4'h7 && command_o == 4'h3
      |=> command_o == 4'h3 && sleep_request_bit_o == $past(sleep_request_bit_i))
      else $error("keep code disturbed command");
   a_crc_preset: assert property (cmd_wr_i && cmd_code_i == 4'h3
      && self_test_field_i != seq_pkg::SELFTEST_ON
      |=> crc_load_o && crc_preset_o == $past(crc_preset_field_i))
      else $error("crc preset not loaded");
   // idle stays quiet once settled
   a_idle_quiet: assert property (command_o == 4'h0 && $past(command_o) == 4'h0
      |-> !fifo_rd_o && !tx_byte_valid_o && !rx_on_o) else $error("idle busy");
   a_tx_starts: assert property (cmd_wr_i && cmd_code_i == 4'h4 && !fifo_empty_i
      |-> ##[1:4] fifo_rd_o) else $error("transmit did not read");
   a_send_waits: assert property (cmd_wr_i && cmd_code_i == 4'hC ##1
      !start_send_flag_i [*3] |-> !fifo_rd_o && !tx_byte_valid_o)
      else $error("sent before start flag");
   a_rx_on: assert property (cmd_wr_i && cmd_code_i == 4'h8 |-> ##[1:2] rx_on_o)
      else $error("receiver not on");
   a_rx_end_idle: assert property (command_o == 4'h8 && rx_end_i && !cmd_wr_i
      |-> ##[1:2] command_o == 4'h0) else $error("receive did not end");
   a_random_ends: assert property (cmd_wr_i && cmd_code_i == 4'h2 ##1 !cmd_wr_i [*8]
      |-> ##[1:6] command_o == 4'h0) else $error("random did not end");
   a_soft_reset: assert property (cmd_wr_i && cmd_code_i == 4'hF
      |=> ##[0:1] soft_reset_o [*7]) else $error("soft reset too short");
endmodule
bind reader_command_sequencer seq_asserts u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
   .cmd_wr_i(cmd_wr_i), .cmd_code_i(cmd_code_i), .sleep_request_bit_i(sleep_request_bit_i),
   .start_send_flag_i(start_send_flag_i), .crc_preset_field_i(crc_preset_field_i),
   .self_test_field_i(self_test_field_i), .fifo_empty_i(fifo_empty_i),
   .rx_end_i(rx_end_i), .fifo_rd_o(fifo_rd_o), .tx_byte_valid_o(tx_byte_valid_o),
   .rx_on_o(rx_on_o), .crc_load_o(crc_load_o), .crc_preset_o(crc_preset_o),
   .command_o(command_o), .sleep_request_bit_o(sleep_request_bit_o),
   .soft_reset_o(soft_reset_o));

//--- tb/reader_command_sequencer_test.sv
// testbench for the reader command sequencer
// assumes the fifo model on the fifo side; inputs change on falling edges
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
   $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module reader_command_sequencer_test;
   logic       clk_i = 1'b0, rstn_i = 1'b0, cmd_wr_i = 1'b0, sleep_i = 1'b0, start_i = 1'b0;
   logic [3:0] code_i = 4'h0, st_i = 4'h0;
   logic [1:0] pre_i = 2'h0;
   logic       tx_done_i = 1'b1, rx_end_i = 1'b0, auth_done_i = 1'b0;
   logic       fifo_empty, fifo_rd_o, fifo_wr_o, tx_byte_valid_o, tx_active_o, rx_on_o;
   logic       crc_load_o, crc_byte_valid_o, auth_start_o, auth_arg_valid_o;
   logic       sleep_o, rxoff_o, soft_reset_o;
   logic [7:0] fifo_rd_data, fifo_wr_data_o, tx_byte_o, crc_byte_o, auth_arg_o, tx_first;
   logic [1:0] crc_preset_o;
   logic [3:0] command_o;
   int         n_errors = 0, n_tests = 0, n_tx = 0, n_crc = 0, n_arg = 0, n_go = 0, n_srst = 0;
   int         eq;
   // ---------------------------------------------------------------
   // clock, design and far side
   // ---------------------------------------------------------------
   initial forever #20 clk_i = ~clk_i;
   reader_command_sequencer DUT (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_wr_i(cmd_wr_i),
      .cmd_code_i(code_i), .sleep_request_bit_i(sleep_i), .receiver_off_bit_i(!sleep_i),
      .start_send_flag_i(start_i), .crc_preset_field_i(pre_i), .self_test_field_i(st_i),
      .fifo_empty_i(fifo_empty), .fifo_rd_data_i(fifo_rd_data), .fifo_rd_o(fifo_rd_o),
      .fifo_wr_o(fifo_wr_o), .fifo_wr_data_o(fifo_wr_data_o),
      .tx_byte_valid_o(tx_byte_valid_o), .tx_byte_o(tx_byte_o), .tx_active_o(tx_active_o),
      .tx_done_i(tx_done_i), .rx_on_o(rx_on_o), .rx_end_i(rx_end_i),
      .crc_load_o(crc_load_o), .crc_preset_o(crc_preset_o),
      .crc_byte_valid_o(crc_byte_valid_o), .crc_byte_o(crc_byte_o),
      .auth_start_o(auth_start_o), .auth_arg_valid_o(auth_arg_valid_o),
      .auth_arg_o(auth_arg_o), .auth_done_i(auth_done_i), .command_o(command_o),
      .sleep_request_bit_o(sleep_o), .receiver_off_bit_o(rxoff_o),
      .soft_reset_o(soft_reset_o));
   fifo_model u_fifo (.clk_i(clk_i), .rd_i(fifo_rd_o), .wr_i(fifo_wr_o),
      .wdata_i(fifo_wr_data_o), .empty_o(fifo_empty), .rdata_o(fifo_rd_data));
   // pulse counters on the far-side strobes
   always @(posedge clk_i) begin
      if (tx_byte_valid_o && n_tx == 0) tx_first = tx_byte_o;
      if (tx_byte_valid_o) n_tx++;
      if (crc_byte_valid_o) n_crc++;
      if (auth_arg_valid_o) n_arg++;
      if (auth_start_o) n_go++;
      if (soft_reset_o) n_srst++;
   end
   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task automatic summarize();
      if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one write pulse, then a gap cycle so two writes never share an edge
   task automatic cmd(input logic [3:0] c);
      @(negedge clk_i);
      code_i = c;
      cmd_wr_i = 1'b1;
      @(negedge clk_i);
      cmd_wr_i = 1'b0;
   endtask
   task automatic wait_cmd(input logic [3:0] c, input int lim);
      int k;
      k = 0;
      while (command_o !== c && k < lim) begin
         @(negedge clk_i);
         k++;
      end
      if (command_o !== c) begin
         n_errors++;
         summarize();
      end
      // one more edge so a strobe launched with the end lands in the model
      @(negedge clk_i);
   endtask
   task automatic push(input int n, input logic [7:0] b);
      for (int i = 0; i < n; i++) u_fifo.q.push_back(b + 8'(i));
   endtask
   task automatic pulse_cycles(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // hang guard
   initial begin
      #4000000;
      n_errors++;
      summarize();
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      pulse_cycles(2);
      rstn_i = 1'b1;
      `CHK("reset command", 4'h0, command_o)
      push(25, 8'h10);
      cmd(4'h1);
      wait_cmd(4'h0, 200);
      `CHK("fifo left after store", 0, u_fifo.q.size())
      rstn_i = 1'b0;
      pulse_cycles(1);
      rstn_i = 1'b1;
      cmd(4'h1);
      wait_cmd(4'h0, 200);
      `CHK("readback count", 25, u_fifo.q.size())
      `CHK("readback last byte", 8'h28, u_fifo.q[24])
      u_fifo.q.delete();
      cmd(4'h2);
      wait_cmd(4'h0, 40);
      cmd(4'h1);
      wait_cmd(4'h0, 200);
      eq = 0;
      foreach (u_fifo.q[i]) if (u_fifo.q[i] === 8'h10 + 8'(i)) eq++;
      `CHK("bytes kept by random", 1'b1, eq >= 15)
      u_fifo.q.delete();
      pre_i = 2'h2;
      n_crc = 0;
      push(3, 8'h40);
      cmd(4'h3);
      `CHK("crc load", 1'b1, crc_load_o)
      `CHK("crc preset", 2'h2, crc_preset_o)
      pulse_cycles(12);
      `CHK("crc bytes", 3, n_crc)
      push(2, 8'h50);
      pulse_cycles(12);
      `CHK("crc bytes resumed", 5, n_crc)
      `CHK("crc last byte", 8'h51, crc_byte_o)
      sleep_i = 1'b1;
      cmd(4'h7);
      `CHK("command kept", 4'h3, command_o)
      `CHK("sleep bit", 1'b1, sleep_o)
      `CHK("receiver-off bit", 1'b0, rxoff_o)
      cmd(4'h0);
      `CHK("idle cancels", 4'h0, command_o)
      sleep_i = 1'b0;
      st_i = seq_pkg::SELFTEST_ON;
      cmd(4'h3);
      pulse_cycles(200);
      `CHK("self-test bytes", 63, u_fifo.q.size())
      cmd(4'h0);
      st_i = 4'h0;
      u_fifo.q.delete();
      n_tx = 0;
      tx_done_i = 1'b0;
      push(4, 8'h60);
      cmd(4'h4);
      pulse_cycles(20);
      `CHK("tx waits transmitter", 4'h4, command_o)
      `CHK("tx active", 1'b1, tx_active_o)
      tx_done_i = 1'b1;
      wait_cmd(4'h0, 100);
      `CHK("tx count", 4, n_tx)
      `CHK("tx first byte", 8'h60, tx_first)
      n_tx = 0;
      push(2, 8'h70);
      cmd(4'hC);
      pulse_cycles(6);
      `CHK("tx before start", 0, n_tx)
      start_i = 1'b1;
      pulse_cycles(40);
      start_i = 1'b0;
      `CHK("tx after start", 2, n_tx)
      `CHK("rx after tx", 1'b1, rx_on_o)
      rx_end_i = 1'b1;
      pulse_cycles(1);
      rx_end_i = 1'b0;
      pulse_cycles(2);
      `CHK("transceive stays", 4'hC, command_o)
      cmd(4'h8);
      pulse_cycles(2);
      `CHK("receiver on", 1'b1, rx_on_o)
      rx_end_i = 1'b1;
      pulse_cycles(1);
      rx_end_i = 1'b0;
      pulse_cycles(2);
      `CHK("receive ends", 4'h0, command_o)
      push(12, 8'h80);
      cmd(4'hE);
      pulse_cycles(40);
      `CHK("auth args", 12, n_arg)
      `CHK("auth start", 1, n_go)
      `CHK("auth last arg", 8'h8B, auth_arg_o)
      auth_done_i = 1'b1;
      pulse_cycles(1);
      auth_done_i = 1'b0;
      pulse_cycles(2);
      `CHK("auth ends", 4'h0, command_o)
      push(25, 8'h90);
      cmd(4'h1);
      cmd(4'h0);
      `CHK("abandoned store", 4'h0, command_o)
      pulse_cycles(10);
      `CHK("bytes left after abandon", 24, u_fifo.q.size())
      u_fifo.q.delete();
      for (int i = 0; i < 6; i++) begin
         cmd(4'h3);
         cmd(i < 2 ? 4'(5 + i) : (i < 5 ? 4'(7 + i) : 4'hD));
         `CHK("undefined code idles", 4'h0, command_o)
      end
      n_srst = 0;
      sleep_i = 1'b1;
      cmd(4'hF);
      wait_cmd(4'h0, 40);
      `CHK("soft reset held", 8, n_srst)
      `CHK("soft reset clears sleep", 1'b0, sleep_o)
      summarize();
   end
endmodule
